// >>> pkg/cache_ctl_pkg.sv
package cache_ctl_pkg;
  localparam int ADDR_W       = 32;
  localparam int LINE_OFS_W   = 4;
  localparam int INDEX_W      = 7;
  localparam int LINES        = 128;
  localparam int TAG_W        = ADDR_W - INDEX_W - LINE_OFS_W;
  localparam int FILL_BEATS   = 8;
  localparam logic [2:0] BEAT_LAST = 3'h7;
  localparam logic [2:0] BEAT_RST  = 3'h0;
  localparam logic [INDEX_W-1:0] INDEX_RST = 7'h00;

  typedef enum logic [1:0] {
    FILL_IDLE  = 2'b00,
    FILL_FIRST = 2'b01,
    FILL_BEATS_ST = 2'b10
  } fill_state_t;

  typedef struct packed {
    logic              valid;
    logic [INDEX_W-1:0] index;
    logic [TAG_W-1:0]   tag;
  } tag_write_t;

  typedef struct packed {
    logic              valid;
    logic [INDEX_W-1:0] index;
    logic [TAG_W-1:0]   tag;
  } snoop_req_t;

  function automatic logic [INDEX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
    return a[LINE_OFS_W +: INDEX_W];
  endfunction

  function automatic logic [TAG_W-1:0] addr_tag(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: TAG_W];
  endfunction
endpackage

// >>> design/sync_2ff.sv
`timescale 1ns/1ns
`default_nettype none
module sync_2ff (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic sync_q;

  // reset to idle-high level of an active-low input
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> design/tag_store.sv
`timescale 1ns/1ns
`default_nettype none
module tag_store
  import cache_ctl_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire cache_ctl_pkg::tag_write_t wr,
  input  wire cache_ctl_pkg::snoop_req_t snoop,
  input  wire logic                      flush_all,
  input  wire logic [cache_ctl_pkg::INDEX_W-1:0] look_index,
  output logic                           look_valid,
  output logic [cache_ctl_pkg::TAG_W-1:0] look_tag,
  output logic                           snoop_hit
);
  logic [LINES-1:0] valid_q;
  logic [TAG_W-1:0] tag_q [LINES];

  assign snoop_hit = snoop.valid && valid_q[snoop.index] && (tag_q[snoop.index] == snoop.tag);

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      // flush beats fill and snoop: a flushed line must never survive
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          valid_q[g] <= 1'b0;
        end else if (flush_all) begin
          valid_q[g] <= 1'b0;
        end else if (wr.valid && wr.index == g) begin
          // a fill landing in the slot replaces the snooped old line
          valid_q[g] <= 1'b1;
        end else if (snoop_hit && snoop.index == g) begin
          valid_q[g] <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (wr.valid && wr.index == g) begin
          tag_q[g] <= wr.tag;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      look_valid <= 1'b0;
      look_tag   <= '0;
    end else begin
      look_valid <= valid_q[look_index];
      look_tag   <= tag_q[look_index];
    end
  end
endmodule
`default_nettype wire

// >>> design/cache_snoop_fill_control.sv
`timescale 1ns/1ns
`default_nettype none
module cache_snoop_fill_control
  import cache_ctl_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire logic                             address_hold_request,
  input  wire logic                             external_address_strobe_n,
  input  wire logic                             cacheable_enable_n,
  input  wire logic                             burst_transfer_done_n,
  input  wire logic                             ready_n,
  input  wire logic                             cache_flush_n,
  input  wire logic                             cycle_start,
  input  wire logic                             cycle_cacheable,
  input  wire logic [cache_ctl_pkg::ADDR_W-1:0] core_addr,
  input  wire logic [cache_ctl_pkg::ADDR_W-1:0] addr_in,
  output logic      [cache_ctl_pkg::ADDR_W-1:0] addr_out,
  output logic                                  addr_oe_n,
  output logic                                  fill_active,
  output logic                                  line_written,
  output logic                                  snoop_invalidated,
  output logic                                  flush_done,
  output logic                                  look_valid,
  output logic [cache_ctl_pkg::TAG_W-1:0]       look_tag
);
  import cache_ctl_pkg::*;

  logic        hold_q;
  logic        ken_q;
  logic        ack;
  logic        flush_sync;
  logic        flush_sync_q;
  logic        flush_pend_q;
  logic        snoop_hit;
  logic [2:0]  beat_q;
  logic [ADDR_W-1:0] fill_addr_q;
  fill_state_t state_q;
  tag_write_t  wr;
  snoop_req_t  snoop;
  logic        ken_ack;
  logic        last_ack;
  logic        keep_line;
  logic        fill_begin;
  logic        flush_edge;
  logic [INDEX_W-1:0] look_index;

  // last beat decode, shared by the sequencer and the keep test
  function automatic logic beat_is_last(input logic [2:0] beat);
    return beat == BEAT_LAST;
  endfunction

  // either acknowledge ends a transfer
  assign ack = !ready_n || !burst_transfer_done_n;

  // a cacheable read start is the only way into a fill
  assign fill_begin = cycle_start && cycle_cacheable;

  // enable was seen one clock before this ack
  assign ken_ack = ack && ken_q;

  // ack that completes the eighth transfer
  assign last_ack = ack && beat_is_last(beat_q);

  // a burst ack on the last beat never keeps the line
  assign keep_line = fill_active && beat_is_last(beat_q) && !ready_n && ken_q;

  // one-clock delayed release, matching the pin's next-clock float
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= address_hold_request;
    end
  end

  // only the address lines float; other outputs are untouched
  assign addr_oe_n = hold_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_out <= '0;
    end else if (state_q == FILL_IDLE) begin
      addr_out <= core_addr;
    end
  end

  // previous-clock sample gives the "one clock before ack" point
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ken_q <= 1'b0;
    end else begin
      ken_q <= !cacheable_enable_n;
    end
  end

  // fill sequencer; an uncached first transfer ends the cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= FILL_IDLE;
    end else begin
      case (state_q)
        FILL_IDLE: begin
          if (fill_begin) begin
            state_q <= FILL_FIRST;
          end
        end
        FILL_FIRST: begin
          if (ken_ack) begin
            state_q <= FILL_BEATS_ST;
          end else if (ack) begin
            state_q <= FILL_IDLE;
          end
        end
        FILL_BEATS_ST: begin
          if (last_ack) begin
            state_q <= FILL_IDLE;
          end
        end
        default: begin
          state_q <= FILL_IDLE;
        end
      endcase
    end
  end

  // beat counter only moves on acks inside a fill
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      beat_q <= BEAT_RST;
    end else begin
      case (state_q)
        FILL_IDLE: begin
          beat_q <= BEAT_RST;
        end
        FILL_FIRST: begin
          if (ken_ack) begin
            beat_q <= BEAT_RST + 3'h1;
          end
        end
        FILL_BEATS_ST: begin
          if (last_ack) begin
            beat_q <= BEAT_RST;
          end else if (ack) begin
            beat_q <= beat_q + 3'h1;
          end
        end
        default: begin
          beat_q <= BEAT_RST;
        end
      endcase
    end
  end

  // line address captured at cycle start, held for the whole fill
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fill_addr_q <= '0;
    end else if (state_q == FILL_IDLE && fill_begin) begin
      fill_addr_q <= core_addr;
    end
  end

  assign fill_active = (state_q == FILL_BEATS_ST);

  // keep only on a non-burst ack at the last beat with enable one clock earlier
  always_comb begin
    wr       = '0;
    wr.index = addr_index(fill_addr_q);
    wr.tag   = addr_tag(fill_addr_q);
    wr.valid = keep_line;
  end

  // snooped address taken off the pins while strobe is low
  always_comb begin
    snoop       = '0;
    snoop.valid = !external_address_strobe_n;
    snoop.index = addr_index(addr_in);
    snoop.tag   = addr_tag(addr_in);
  end

  sync_2ff u_flush_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (cache_flush_n),
    .sync_out (flush_sync)
  );

  // previous synchronised level, idle high like the pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flush_sync_q <= 1'b1;
    end else begin
      flush_sync_q <= flush_sync;
    end
  end

  // falling edge only: a long low gives one flush, not one per clock
  assign flush_edge = flush_sync_q && !flush_sync;

  // edge capture so a one-clock low is never missed
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flush_pend_q <= 1'b0;
    end else begin
      flush_pend_q <= flush_edge;
    end
  end

  // lookup follows the core address index
  assign look_index = addr_index(core_addr);

  tag_store u_tags (
    .clk        (clk),
    .rst_b      (rst_b),
    .wr         (wr),
    .snoop      (snoop),
    .flush_all  (flush_pend_q),
    .look_index (look_index),
    .look_valid (look_valid),
    .look_tag   (look_tag),
    .snoop_hit  (snoop_hit)
  );

  // write reported one clock later; a flush in the same clock wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_written <= 1'b0;
    end else begin
      line_written <= wr.valid && !flush_pend_q;
    end
  end

  // invalidation reported one clock after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      snoop_invalidated <= 1'b0;
    end else begin
      snoop_invalidated <= snoop_hit && !flush_pend_q;
    end
  end

  // one pulse per recognised flush
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flush_done <= 1'b0;
    end else begin
      flush_done <= flush_pend_q;
    end
  end
endmodule
`default_nettype wire

// >>> bench/cache_snoop_fill_control_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module cache_snoop_fill_control_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic address_hold_request,
  input wire logic external_address_strobe_n,
  input wire logic cacheable_enable_n,
  input wire logic burst_transfer_done_n,
  input wire logic ready_n,
  input wire logic cache_flush_n,
  input wire logic addr_oe_n,
  input wire logic fill_active,
  input wire logic line_written,
  input wire logic snoop_invalidated,
  input wire logic flush_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_HOLD_OFF: assert property (address_hold_request |=> addr_oe_n)
    else $error("address driven in hold");
  AST_HOLD_ON: assert property (!address_hold_request |=> !addr_oe_n)
    else $error("address released without hold");
  AST_FILL_KEN: assert property ($rose(fill_active) |->
    !$past(cacheable_enable_n, 2) && !($past(ready_n) && $past(burst_transfer_done_n)))
    else $error("fill without enable");
  AST_WRITE_KEN: assert property (line_written |->
    !$past(ready_n) && !$past(cacheable_enable_n, 2) && $past(fill_active))
    else $error("line written wrongly");
  AST_LINE_PULSE: assert property (line_written |=> !line_written)
    else $error("line write too long");
  AST_SNOOP_STROBE: assert property (snoop_invalidated |->
    !$past(external_address_strobe_n))
    else $error("invalidate without strobe");
  AST_FLUSH_DONE: assert property ($fell(cache_flush_n) |-> ##[3:4] flush_done)
    else $error("flush not seen");
  AST_FLUSH_PULSE: assert property (flush_done |=> !flush_done)
    else $error("flush done too long");
endmodule
`default_nettype wire

// >>> bench/fill_partner.sv
`timescale 1ns/1ns
`default_nettype none
module fill_partner (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       keep,
  input  wire logic [1:0] slow,
  output logic            ken_n,
  output logic            rdy_n,
  output logic            burst_transfer_done_n_n
);
  initial {ken_n, rdy_n, burst_transfer_done_n_n} = 3'h7;
  // acks idle high, enable rests at its pull-up level
  always @(posedge clk) if (go) begin
    #1 ken_n = 1'h0;
    repeat (1 + slow) @(posedge clk);
    #1 burst_transfer_done_n_n = 1'h0;
    repeat (6) @(posedge clk);
    #1 ken_n = !keep;
    @(posedge clk) #1 burst_transfer_done_n_n = 1'h1;
    rdy_n = 1'h0;
    @(posedge clk) #1 {ken_n, rdy_n} = 2'h3;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cache_ctl_pkg::*;
  logic              clk = 1'h0;
  logic              rst_b = 1'h0;
  logic              address_hold_request = 1'h0;
  logic              external_address_strobe_n = 1'h1;
  logic              cache_flush_n = 1'h1;
  logic              cycle_start = 1'h0;
  logic              cycle_cacheable = 1'h1;
  logic [ADDR_W-1:0] addr_out;
  logic              go = 1'h0;
  logic              keep = 1'h0;
  logic [1:0]        slow = 2'h0;
  logic [ADDR_W-1:0] core_addr = '0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [ADDR_W-1:0] a;
  wire logic         cacheable_enable_n, burst_transfer_done_n, ready_n;
  logic              line_written, snoop_invalidated, flush_done, look_valid;
  logic [TAG_W-1:0]  look_tag;
  logic [2:0]        exp_q[$];
  int                n_fail = 0;
  int                cmp_count = 0;
  always #10 clk = ~clk;
  fill_partner ptn (.clk, .go, .keep, .slow, .ken_n(cacheable_enable_n),
    .rdy_n(ready_n), .burst_transfer_done_n_n(burst_transfer_done_n));
  cache_snoop_fill_control dut (.clk, .rst_b, .address_hold_request,
    .external_address_strobe_n, .cacheable_enable_n, .burst_transfer_done_n, .ready_n,
    .cache_flush_n, .cycle_start, .cycle_cacheable, .core_addr, .addr_in,
    .addr_out, .addr_oe_n(), .fill_active(), .line_written, .snoop_invalidated,
    .flush_done, .look_valid, .look_tag);
  wire logic [2:0]   got = {line_written, snoop_invalidated, flush_done};
  // every result pulse must match the oldest note
  always @(posedge clk) #2 if (got !== 3'h0) begin
    cmp_count++;
    if (exp_q.size() == 0 || exp_q[0] !== got) begin
      n_fail++;
      $display("wrong value at %0t: event %b", $time, got);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  end
  task automatic fill(input logic [ADDR_W-1:0] ad, input logic k, input logic [1:0] s);
    core_addr = ad;
    {keep, slow, cycle_start, go} = {k, s, 2'h3};
    if (k && cycle_cacheable) exp_q.push_back(3'h4);
    @(posedge clk) #1 {cycle_start, go} = 2'h0;
    repeat (13 + s) @(posedge clk);
    #1;
  endtask
  task automatic look(input logic [ADDR_W-1:0] ad, input logic v);
    core_addr = ad;
    repeat (2) @(posedge clk);
    #1 cmp_count++;
    if (look_valid !== v || (v && look_tag !== ad[ADDR_W-1 -: TAG_W])) begin
      n_fail++;
      $display("wrong value at %0t: lookup %h", $time, ad);
    end
    cmp_count++;
    if (addr_out !== ad) begin
      n_fail++;
      $display("wrong value at %0t: address out %h", $time, addr_out);
    end
  endtask
  task automatic snoop(input logic [ADDR_W-1:0] ad, input logic hit);
    address_hold_request = 1'h1;
    @(posedge clk) #1 addr_in = ad;
    external_address_strobe_n = 1'h0;
    if (hit) exp_q.push_back(3'h2);
    @(posedge clk) #1 {external_address_strobe_n, address_hold_request} = 2'h2;
    addr_in = ~ad; // released pins never keep the old address
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    if (exp_q.size() != 0) n_fail++;
    $display("compares %0d, wrong %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hd32c0be8));
    a = $urandom();
    repeat (16) @(posedge clk);
    #1 rst_b = 1'h1;
    address_hold_request = 1'h1;
    fill(a, 1'h1, 2'h0);
    address_hold_request = 1'h0;
    look(a, 1'h1);
    fill(a ^ 32'h10, 1'h0, 2'h2);
    look(a ^ 32'h10, 1'h0);
    cycle_cacheable = 1'h0;
    fill(a ^ 32'h20, 1'h1, 2'h0);
    cycle_cacheable = 1'h1;
    look(a ^ 32'h20, 1'h0);
    $display("fill test end");
    snoop(a ^ 32'h80000000, 1'h0);
    look(a, 1'h1);
    snoop(a, 1'h1);
    look(a, 1'h0);
    $display("snoop test end");
    fill(a, 1'h1, 2'h1);
    fill(a ^ 32'h10, 1'h1, 2'h3);
    cache_flush_n = 1'h0;
    exp_q.push_back(3'h1);
    @(posedge clk) #1 cache_flush_n = 1'h1;
    repeat (6) @(posedge clk);
    #1 look(a, 1'h0);
    look(a ^ 32'h10, 1'h0);
    $display("flush test end");
    summarize;
  end
  initial begin
    #40000 n_fail++;
    summarize;
  end
endmodule
bind cache_snoop_fill_control cache_snoop_fill_control_monitor mon (.clk, .rst_b,
  .address_hold_request, .external_address_strobe_n, .cacheable_enable_n,
  .burst_transfer_done_n, .ready_n, .cache_flush_n, .addr_oe_n, .fill_active,
  .line_written, .snoop_invalidated, .flush_done);
`default_nettype wire
